// *** src/pm_defines.svh ***
// constants for the peripheral power-mode controller
// How it works
// - doze and nap keep pci address decode, the pci arbiter and memory refresh running.
// - doze and nap keep bus-request and nmi watching, the irq controller, serial unit and pll on.
// - doze returns to full power on pci memory access, bus request, nmi, irq or hard reset.
// - nap and sleep are entered only on a software request while the core is napping or asleep.
// - sleep stops pci address decode, keeps the arbiter, and keeps refresh unless software drops it.
// - sleep keeps the irq controller and serial unit, and the pll unless software disables it.
// - sleep wakes only on bus request, nmi, irq or hard reset, never on pci memory access.
// - a pci memory access in nap is serviced with quiesce acknowledge held asserted.
// - a pci memory access in nap is not passed to the core for snooping.
// - after a nap-time pci access the logic goes back to nap by itself.
// - full power enables every unit with no restriction.
// - quiesce acknowledge is raised only after the core reports nap or sleep, and the core wakes on its negation.
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH
`define PM_MODE_FULL 2'h0
`define PM_MODE_DOZE 2'h1
`define PM_MODE_NAP 2'h2
`define PM_MODE_SLEEP 2'h3
`define PM_CTRL_RESET 2'h0
`define PM_SYNC_STAGES 2
`endif

// *** src/pm_pkg.sv ***
// types for the peripheral power-mode controller
package pm_pkg;
    typedef enum logic [1:0] {ST_FULL, ST_DOZE, ST_NAP, ST_SLEEP} pm_state_t;
    typedef logic [1:0] pm_mode_t;
endpackage

// *** src/pm_wake_detect.sv ***
// combines the wake sources into one request, filtered by the present mode
`timescale 1ns/100ps
`include "pm_defines.svh"
module pm_wake_detect (
    input wire logic [1:0] mode, // present power mode code
    input wire logic pci_mem_access, // pci access to memory
    input wire logic bus_request, // processor bus request
    input wire logic nmi, // non-maskable interrupt
    input wire logic irq, // interrupt to the irq controller
    output logic wake // wake request
);
    // pci memory access wakes doze only; nap serves it in place, sleep ignores it
    wire logic common_wake = bus_request | nmi | irq;
    assign wake = (mode == `PM_MODE_DOZE) ? (common_wake | pci_mem_access) :
                  (mode == `PM_MODE_FULL) ? 1'b0 : common_wake;
endmodule

// *** src/pm_controller.sv ***
// peripheral logic power-mode controller
`timescale 1ns/100ps
`include "pm_defines.svh"
module pm_controller (
    input wire logic CLK, // peripheral bus clock
    input wire logic RST, // hard reset, async, active high
    input wire logic CTRL_WE, // power control register write strobe
    input wire logic [1:0] CTRL_MODE, // requested mode
    input wire logic CTRL_SLEEP_NO_REFRESH, // drop refresh in sleep
    input wire logic CTRL_SLEEP_NO_PLL, // stop pll in sleep
    input wire logic CORE_NAP_SLEEP, // core is in nap or sleep
    input wire logic PCI_MEM_ACCESS, // pci access to memory, level while active
    input wire logic BUS_REQUEST, // processor bus request
    input wire logic NMI, // non-maskable interrupt
    input wire logic IRQ, // interrupt to irq controller
    output logic [1:0] MODE, // present power mode
    output logic CORE_QUIESCE_ACK, // quiesce acknowledge to core
    output logic PCI_DECODE_EN, // pci address decode enable
    output logic PCI_ARB_EN, // pci arbiter enable
    output logic REFRESH_EN, // memory refresh enable
    output logic MONITOR_EN, // bus request and nmi watch enable
    output logic IRQ_CTRL_EN, // irq controller enable
    output logic SERIAL_EN, // serial controller enable
    output logic PLL_EN, // pll enable
    output logic SNOOP_EN, // present pci accesses to core for snooping
    output logic FULL_EN // units needed only at full power
);
    pm_pkg::pm_state_t state_reg, state_next;
    logic [1:0] power_mgmt_control_reg;
    logic no_refresh_reg, no_pll_reg;
    wire logic wake;
    wire logic [1:0] mode_code;

    // software settings held in the power control register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            power_mgmt_control_reg <= `PM_CTRL_RESET;
            no_refresh_reg <= 1'b0;
            no_pll_reg <= 1'b0;
        end else if (wake) begin
            power_mgmt_control_reg <= `PM_MODE_FULL;
        end else if (CTRL_WE) begin
            power_mgmt_control_reg <= CTRL_MODE;
            no_refresh_reg <= CTRL_SLEEP_NO_REFRESH;
            no_pll_reg <= CTRL_SLEEP_NO_PLL;
        end
    end

    // maps a sequencer state to the mode code seen by software and the wake filter
    function automatic logic [1:0] state_code(input pm_pkg::pm_state_t st);
        logic [1:0] code;
        case (st)
            pm_pkg::ST_DOZE: code = `PM_MODE_DOZE;
            pm_pkg::ST_NAP: code = `PM_MODE_NAP;
            pm_pkg::ST_SLEEP: code = `PM_MODE_SLEEP;
            default: code = `PM_MODE_FULL;
        endcase
        return code;
    endfunction

    // state code used by the wake filter
    assign mode_code = state_code(state_reg);

    pm_wake_detect u_wake (
        .mode(mode_code),
        .pci_mem_access(PCI_MEM_ACCESS),
        .bus_request(BUS_REQUEST),
        .nmi(NMI),
        .irq(IRQ),
        .wake(wake)
    );

    // mode sequencing; a pci access in nap keeps state nap, so it resumes by itself
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pm_pkg::ST_FULL: begin
                if (power_mgmt_control_reg == `PM_MODE_DOZE) begin
                    state_next = pm_pkg::ST_DOZE;
                end else if (power_mgmt_control_reg == `PM_MODE_NAP && CORE_NAP_SLEEP) begin
                    state_next = pm_pkg::ST_NAP;
                end else if (power_mgmt_control_reg == `PM_MODE_SLEEP && CORE_NAP_SLEEP) begin
                    state_next = pm_pkg::ST_SLEEP;
                end
            end
            pm_pkg::ST_DOZE, pm_pkg::ST_NAP, pm_pkg::ST_SLEEP: begin
                if (wake) begin
                    state_next = pm_pkg::ST_FULL;
                end
            end
            default: state_next = pm_pkg::ST_FULL;
        endcase
    end

    // next-state decode shared by the output flops, so every output comes from a flop
    wire logic nx_full = (state_next == pm_pkg::ST_FULL);
    wire logic nx_sleep = (state_next == pm_pkg::ST_SLEEP);
    wire logic nx_nap = (state_next == pm_pkg::ST_NAP);
    wire logic nx_quiet = nx_nap | nx_sleep; // core is to stay quiesced
    wire logic [1:0] mode_next = state_code(state_next);

    // next unit enables; arbiter, monitors, irq and serial units never stop
    wire logic ack_next = nx_quiet;
    wire logic decode_en_next = ~nx_sleep;
    wire logic arb_en_next = 1'b1;
    wire logic refresh_en_next = ~(nx_sleep & no_refresh_reg);
    wire logic monitor_en_next = 1'b1;
    wire logic irq_ctrl_en_next = 1'b1;
    wire logic serial_en_next = 1'b1;
    wire logic pll_en_next = ~(nx_sleep & no_pll_reg);
    wire logic snoop_en_next = ~nx_quiet;
    wire logic full_en_next = nx_full;

    // sequencer state, mode code and the core handshake
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= pm_pkg::ST_FULL;
            MODE <= `PM_MODE_FULL;
            CORE_QUIESCE_ACK <= 1'b0;
        end else begin
            state_reg <= state_next;
            MODE <= mode_next;
            CORE_QUIESCE_ACK <= ack_next;
        end
    end

    // enables on the pci and memory side
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PCI_DECODE_EN <= 1'b1;
            PCI_ARB_EN <= 1'b1;
            REFRESH_EN <= 1'b1;
            SNOOP_EN <= 1'b1;
        end else begin
            PCI_DECODE_EN <= decode_en_next;
            PCI_ARB_EN <= arb_en_next;
            REFRESH_EN <= refresh_en_next;
            SNOOP_EN <= snoop_en_next;
        end
    end

    // enables on the core and service side
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            MONITOR_EN <= 1'b1;
            IRQ_CTRL_EN <= 1'b1;
            SERIAL_EN <= 1'b1;
            PLL_EN <= 1'b1;
            FULL_EN <= 1'b1;
        end else begin
            MONITOR_EN <= monitor_en_next;
            IRQ_CTRL_EN <= irq_ctrl_en_next;
            SERIAL_EN <= serial_en_next;
            PLL_EN <= pll_en_next;
            FULL_EN <= full_en_next;
        end
    end

    // checks
    a_nap_entry_gate: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == pm_pkg::ST_FULL && !CORE_NAP_SLEEP) |=> !CORE_QUIESCE_ACK)
        else $error("quiesce ack without core in nap or sleep");
    a_sleep_pci_hold: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == pm_pkg::ST_SLEEP && PCI_MEM_ACCESS && !BUS_REQUEST && !NMI && !IRQ)
        |=> CORE_QUIESCE_ACK)
        else $error("pci access woke sleep");
    a_nap_pci_hold: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == pm_pkg::ST_NAP && PCI_MEM_ACCESS && !BUS_REQUEST && !NMI && !IRQ)
        |=> CORE_QUIESCE_ACK && !SNOOP_EN)
        else $error("nap pci access negated ack");
    a_doze_pci_wake: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == pm_pkg::ST_DOZE && PCI_MEM_ACCESS) |=> MODE == `PM_MODE_FULL)
        else $error("doze missed pci wake");
    a_wake_clears: assert property (@(posedge CLK) disable iff (RST)
        (CORE_QUIESCE_ACK && (BUS_REQUEST || NMI || IRQ)) |=> !CORE_QUIESCE_ACK)
        else $error("wake did not negate ack");
    a_sleep_decode_off: assert property (@(posedge CLK) disable iff (RST)
        (MODE == `PM_MODE_SLEEP) |-> !PCI_DECODE_EN && PCI_ARB_EN)
        else $error("decode active in sleep");
    a_low_keeps_units: assert property (@(posedge CLK) disable iff (RST)
        (MODE == `PM_MODE_DOZE || MODE == `PM_MODE_NAP) |-> PCI_DECODE_EN && REFRESH_EN && PLL_EN)
        else $error("unit stopped in doze or nap");
    a_full_all_on: assert property (@(posedge CLK) disable iff (RST)
        (MODE == `PM_MODE_FULL) |-> FULL_EN && SNOOP_EN && PLL_EN && REFRESH_EN)
        else $error("unit off at full power");

    // a finished nap-time pci access leaves the logic in nap with the core quiesced
    a_nap_resume: assert property (@(posedge CLK) disable iff (RST)
        ($fell(PCI_MEM_ACCESS) && state_reg == pm_pkg::ST_NAP && !BUS_REQUEST && !NMI && !IRQ)
        |=> MODE == `PM_MODE_NAP && CORE_QUIESCE_ACK)
        else $error("nap not resumed after pci access");

    // doze answers a bus request, nmi or irq with full power
    a_doze_src_wake: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == pm_pkg::ST_DOZE && (BUS_REQUEST || NMI || IRQ)) |=> MODE == `PM_MODE_FULL)
        else $error("doze missed wake source");

    // a wake from sleep leaves no stale selection behind to re-enter sleep
    a_sleep_wake_clear: assert property (@(posedge CLK) disable iff (RST)
        (state_reg == pm_pkg::ST_SLEEP && (BUS_REQUEST || NMI || IRQ))
        |=> MODE == `PM_MODE_FULL && !CORE_QUIESCE_ACK && FULL_EN
            && power_mgmt_control_reg == `PM_MODE_FULL)
        else $error("sleep wake left mode selected");

    // the arbiter, bus monitors, irq controller and serial unit run in every mode
    a_units_always_on: assert property (@(posedge CLK) disable iff (RST)
        PCI_ARB_EN && MONITOR_EN && IRQ_CTRL_EN && SERIAL_EN)
        else $error("always-on unit stopped");

    // quiesce acknowledge stands only while nap or sleep is shown
    a_ack_quiet_only: assert property (@(posedge CLK) disable iff (RST)
        CORE_QUIESCE_ACK |-> (MODE == `PM_MODE_NAP || MODE == `PM_MODE_SLEEP) && !SNOOP_EN)
        else $error("quiesce ack outside nap or sleep");

    // doze needs no core handshake and keeps snooping
    a_doze_no_ack: assert property (@(posedge CLK) disable iff (RST)
        (MODE == `PM_MODE_DOZE) |-> !CORE_QUIESCE_ACK && SNOOP_EN && !FULL_EN)
        else $error("doze drove quiesce ack");

    // a wake beats a write in the same cycle, so the selection is full power after it
    a_wake_beats_write: assert property (@(posedge CLK) disable iff (RST)
        (wake && CTRL_WE) |=> power_mgmt_control_reg == `PM_MODE_FULL && MODE == `PM_MODE_FULL)
        else $error("write overrode a wake");

    // refresh and pll follow the sleep options while sleep is shown
    a_sleep_options: assert property (@(posedge CLK) disable iff (RST)
        (MODE == `PM_MODE_SLEEP && $stable(no_refresh_reg) && $stable(no_pll_reg))
        |-> REFRESH_EN == !no_refresh_reg && PLL_EN == !no_pll_reg)
        else $error("sleep options not applied");
endmodule

// *** tb/core_model.sv ***
// behavioural model of the processor core quiesce handshake
`timescale 1ns/100ps
module core_model (
    input wire logic clk, // peripheral bus clock
    input wire logic rst, // hard reset
    input wire logic nap_req, // core software asks for nap
    input wire logic quiesce_ack, // acknowledge from the controller
    output logic nap_sleep // core is napping
);
    logic ack_q_reg;
    // core naps on request and wakes as soon as acknowledge drops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q_reg <= 1'b0;
            nap_sleep <= 1'b0;
        end else begin
            ack_q_reg <= quiesce_ack;
            nap_sleep <= nap_req && !(ack_q_reg && !quiesce_ack);
        end
    end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the power-mode controller
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, nr = 1'b0, np = 1'b0, nap_req = 1'b0;
    logic pci = 1'b0, breq = 1'b0, nmi = 1'b0, irq = 1'b0;
    logic [1:0] cm = 2'h0;
    wire core_ns;
    wire [11:0] outs;
    int mismatches = 0, compares = 0, cycles = 0;
    pm_controller i_pm_controller (.CLK(clk), .RST(rst), .CTRL_WE(we), .CTRL_MODE(cm),
        .CTRL_SLEEP_NO_REFRESH(nr), .CTRL_SLEEP_NO_PLL(np), .CORE_NAP_SLEEP(core_ns),
        .PCI_MEM_ACCESS(pci), .BUS_REQUEST(breq), .NMI(nmi), .IRQ(irq), .MODE(outs[11:10]),
        .CORE_QUIESCE_ACK(outs[9]), .PCI_DECODE_EN(outs[8]), .PCI_ARB_EN(outs[7]),
        .REFRESH_EN(outs[6]), .MONITOR_EN(outs[5]), .IRQ_CTRL_EN(outs[4]),
        .SERIAL_EN(outs[3]), .PLL_EN(outs[2]), .SNOOP_EN(outs[1]), .FULL_EN(outs[0]));
    core_model i_core_model (.clk(clk), .rst(rst), .nap_req(nap_req),
        .quiesce_ack(outs[9]), .nap_sleep(core_ns));
    // expected mode, acknowledge and unit enables for a mode and the sleep options
    function automatic logic [11:0] expect_outs(input logic [1:0] m, input logic r, p);
        logic sl;
        sl = (m == 2'h3);
        return {m, m[1], !sl, 1'b1, !(sl && r), 3'b111, !(sl && p), !m[1], m == 2'h0};
    endfunction
    // compare and count
    task automatic check(input logic [11:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // clock and hang guard; the tests need well under 1000 cycles
    always #2.5 clk = !clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    // random mode requests, pci traffic and wake events
    initial begin
        logic [1:0] m;
        logic [2:0] src;
        void'($urandom(32'hddea));
        idle(16);
        rst = 1'b0;
        check(outs, expect_outs(2'h0, 1'b0, 1'b0));
        for (int i = 0; i < 40; i++) begin
            m = (i < 4) ? i[1:0] : 2'($urandom_range(3, 1));
            src = 3'h4 >> $urandom_range(2, 0);
            we = 1'b1;
            cm = m;
            nr = 1'($urandom);
            np = 1'($urandom);
            idle(1);
            we = 1'b0;
            idle(3);
            if (m[1]) check(outs, expect_outs(2'h0, 1'b0, 1'b0));
            nap_req = m[1];
            idle(4);
            check(outs, expect_outs(m, nr, np));
            pci = (m != 2'h1) || i[0];
            idle(2);
            if (m == 2'h1 && i[0]) check(outs, expect_outs(2'h0, nr, np));
            else check(outs, expect_outs(m, nr, np));
            pci = 1'b0;
            idle(2);
            if (m != 2'h1 || !i[0]) check(outs, expect_outs(m, nr, np));
            {breq, nmi, irq} = src;
            nap_req = 1'b0;
            idle(1);
            {breq, nmi, irq} = 3'h0;
            idle(3);
            check(outs, expect_outs(2'h0, nr, np));
        end
        // corner: a write that meets a wake in nap is dropped, the wake wins
        we = 1'b1;
        cm = 2'h2;
        nr = 1'b0;
        np = 1'b0;
        idle(1);
        we = 1'b0;
        nap_req = 1'b1;
        idle(6);
        check(outs, expect_outs(2'h2, 1'b0, 1'b0));
        we = 1'b1;
        cm = 2'h1;
        irq = 1'b1;
        nap_req = 1'b0;
        idle(1);
        we = 1'b0;
        irq = 1'b0;
        idle(3);
        check(outs, expect_outs(2'h0, 1'b0, 1'b0));
        // corner: hard reset in sleep returns everything to full power
        we = 1'b1;
        cm = 2'h3;
        nr = 1'b1;
        np = 1'b1;
        idle(1);
        we = 1'b0;
        nap_req = 1'b1;
        idle(6);
        check(outs, expect_outs(2'h3, 1'b1, 1'b1));
        rst = 1'b1;
        idle(2);
        check(outs, expect_outs(2'h0, 1'b0, 1'b0));
        rst = 1'b0;
        idle(4);
        check(outs, expect_outs(2'h0, 1'b0, 1'b0));
        stop_test();
    end
endmodule
